// ---- adc_seq_pkg.sv ----
// Package: register map, field positions and reset values of the sequence controller
package adc_seq_pkg;

    // Register word offsets (byte address = 4 * index)
    localparam logic [3:0] OFS_CONTROL_TWO   = 4'h0;
    localparam logic [3:0] OFS_CONTROL_THREE = 4'h1;
    localparam logic [3:0] OFS_CONTROL_FOUR  = 4'h2;
    localparam logic [3:0] OFS_CONTROL_FIVE  = 4'h3;
    localparam logic [3:0] OFS_STATUS        = 4'h4;
    localparam logic [3:0] OFS_TEST          = 4'h5;
    localparam logic [3:0] OFS_RESULT0       = 4'h8;

    // Control two fields
    localparam int POS_POWER_UP     = 7;
    localparam int POS_JUSTIFY      = 1;
    localparam int POS_SIGNED       = 0;
    localparam logic [7:0] RST_CONTROL_TWO = 8'h00;

    // Control three fields
    localparam int POS_FIFO_EN      = 1;
    localparam int POS_SINGLE_CONV  = 0;
    localparam logic [7:0] RST_CONTROL_THREE = 8'h00;

    // Control four: conversion time field
    localparam int POS_CONV_TIME_LO = 0;
    localparam int CONV_TIME_W      = 4;
    localparam logic [7:0] RST_CONTROL_FOUR = 8'h01;

    // Control five fields
    localparam int POS_EIGHT_SEQ    = 6;
    localparam int POS_SCAN         = 5;
    localparam int POS_MULTI        = 4;
    localparam int POS_SPECIAL      = 3;
    localparam int POS_CHAN_LO      = 0;
    localparam logic [7:0] RST_CONTROL_FIVE = 8'h00;

    // Status fields
    localparam int POS_SEQ_COMPLETE = 7;
    localparam int POS_BUSY         = 6;
    localparam int POS_CONV_CNT_LO  = 0;

    // Test register fields
    localparam int POS_TEST_RST     = 15;

    // Sequence lengths
    localparam logic [3:0] SEQ_LEN_ONE   = 4'h1;
    localparam logic [3:0] SEQ_LEN_FOUR  = 4'h4;
    localparam logic [3:0] SEQ_LEN_EIGHT = 4'h8;

    // Timing: clocks per approximation step at conversion time field zero
    localparam int STEP_BASE_CYCLES = 2;

    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

endpackage

// ---- adc_sequence_control.sv ----
// Conversion sequencer with Avalon-MM register slave
// What this block does
// - Channel-select bits pick the first channel of a multi-channel sequence, unmasked.
// - Top channel-select bit stays unmasked even in eight-channel sequence mode.
// - Special-channel bit converts internal references; software clears channel bits.
// - Writing control four aborts the running sequence and starts a new one.
// - Writing control two or three never aborts a running sequence.
// - Writing control five aborts, clears conversion flags and starts a new sequence.
// - In continuous scan the complete flag sets after every finished sequence.
// - Reading the test register returns the approximation register contents.
// - Writing the test reset bit resets the converter logic.
// - Eight-channel sequence length kept, overridden by single-conversion select.
// - Control two holds justify and signed bits, reset to unsigned default.
// - Control three holds FIFO and single-conversion bits, reset to old behaviour.
`timescale 1ns/100ps
module adc_sequence_control #(
    parameter int RES_W = 10,
    parameter int DIV_W = 6
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             srst,
    // Avalon-MM slave
    input  wire logic [5:0]       address,
    input  wire logic             read,
    input  wire logic             write,
    input  wire logic [31:0]      writedata,
    output logic [31:0]           readdata,
    output logic                  waitrequest,
    // Analog front end
    input  wire logic             comp_high,
    output logic [2:0]            mux_channel,
    output logic                  internal_reference_select,
    output logic [RES_W-1:0]      dac_level,
    output logic                  sample_en
);
    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_CONVERT, ST_STORE} seq_state_t;

    seq_state_t state;
    logic [7:0] converter_control_two;
    logic [7:0] converter_control_three;
    logic [7:0] converter_control_four;
    logic [7:0] converter_control_five;
    logic       sequence_complete_flag;
    logic [7:0] result_valid;
    logic [RES_W-1:0] results [0:7];
    logic [2:0] cur_channel;
    logic [2:0] conv_index;
    logic [2:0] fifo_slot;
    logic [3:0] seq_len;
    logic       ack_pending;
    logic       conv_reset;
    logic       seq_restart;
    logic       seq_done;
    logic       step_en;
    logic       sar_busy;
    logic       sar_done;
    logic [RES_W-1:0] approximation_register;
    logic       start_conv;
    logic       next_complete;

    wire logic [3:0] reg_index = address[5:2];
    wire logic wr_acc = write && !ack_pending;
    wire logic rd_acc = read && !ack_pending;
    wire logic wr_two   = wr_acc && reg_index == adc_seq_pkg::OFS_CONTROL_TWO;
    wire logic wr_three = wr_acc && reg_index == adc_seq_pkg::OFS_CONTROL_THREE;
    wire logic wr_four  = wr_acc && reg_index == adc_seq_pkg::OFS_CONTROL_FOUR;
    wire logic wr_five  = wr_acc && reg_index == adc_seq_pkg::OFS_CONTROL_FIVE;
    wire logic wr_test  = wr_acc && reg_index == adc_seq_pkg::OFS_TEST;

    wire logic start_channel_bit0 = converter_control_five[adc_seq_pkg::POS_CHAN_LO];
    wire logic start_channel_bit1 = converter_control_five[adc_seq_pkg::POS_CHAN_LO+1];
    wire logic start_channel_bit2 = converter_control_five[adc_seq_pkg::POS_CHAN_LO+2];
    wire logic eight_conversion_sequence = converter_control_five[adc_seq_pkg::POS_EIGHT_SEQ];
    wire logic scan_mode   = converter_control_five[adc_seq_pkg::POS_SCAN];
    wire logic multi_mode  = converter_control_five[adc_seq_pkg::POS_MULTI];
    wire logic single_conversion_select = converter_control_three[adc_seq_pkg::POS_SINGLE_CONV];
    wire logic fifo_enable = converter_control_three[adc_seq_pkg::POS_FIFO_EN];
    wire logic result_justify = converter_control_two[adc_seq_pkg::POS_JUSTIFY];
    wire logic result_signed  = converter_control_two[adc_seq_pkg::POS_SIGNED];

    // Result formatting: justify into 16 bits, signed flips the midscale bit
    function automatic logic [15:0] format_result(input logic [RES_W-1:0] raw,
                                                  input logic justify,
                                                  input logic signed_fmt);
        logic [RES_W-1:0] val;
        logic [15:0]      out;
        val = signed_fmt ? (raw ^ {1'b1, {(RES_W-1){1'b0}}}) : raw;
        out = 16'h0000;
        if (justify)
            out[RES_W-1:0] = val;
        else
            out[15 -: RES_W] = val;
        if (justify && signed_fmt)
            out[15:RES_W] = {(16-RES_W){val[RES_W-1]}};
        return out;
    endfunction

    // Sequence length from the mode bits
    function automatic logic [3:0] pick_length(input logic single, input logic eight);
        if (single)
            return adc_seq_pkg::SEQ_LEN_ONE;
        else if (eight)
            return adc_seq_pkg::SEQ_LEN_EIGHT;
        else
            return adc_seq_pkg::SEQ_LEN_FOUR;
    endfunction

    assign conv_reset  = srst || (wr_test && writedata[adc_seq_pkg::POS_TEST_RST]);
    assign seq_restart = wr_four || wr_five;

    // Bus handshake: one wait cycle per access, answer on second edge
    always_ff @(posedge mclk)
    begin
        if (srst)
            ack_pending <= 1'b0;
        else
            ack_pending <= (read || write) && !ack_pending;
    end
    assign waitrequest = (read || write) && !ack_pending;

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            converter_control_two   <= adc_seq_pkg::RST_CONTROL_TWO;
            converter_control_three <= adc_seq_pkg::RST_CONTROL_THREE;
            converter_control_four  <= adc_seq_pkg::RST_CONTROL_FOUR;
            converter_control_five  <= adc_seq_pkg::RST_CONTROL_FIVE;
        end
        else
        begin
            if (wr_two)
                converter_control_two <= writedata[7:0];
            if (wr_three)
                converter_control_three <= writedata[7:0];
            if (wr_four)
                converter_control_four <= writedata[7:0];
            if (wr_five)
                converter_control_five <= writedata[7:0];
        end
    end

    // Read mux, registered for the answer edge
    always_ff @(posedge mclk)
    begin
        if (srst)
            readdata <= adc_seq_pkg::READ_UNMAPPED;
        else if (rd_acc)
        begin
            readdata <= adc_seq_pkg::READ_UNMAPPED;
            if (reg_index == adc_seq_pkg::OFS_CONTROL_TWO)
                readdata <= {24'h00_0000, converter_control_two};
            else if (reg_index == adc_seq_pkg::OFS_CONTROL_THREE)
                readdata <= {24'h00_0000, converter_control_three};
            else if (reg_index == adc_seq_pkg::OFS_CONTROL_FOUR)
                readdata <= {24'h00_0000, converter_control_four};
            else if (reg_index == adc_seq_pkg::OFS_CONTROL_FIVE)
                readdata <= {24'h00_0000, converter_control_five};
            else if (reg_index == adc_seq_pkg::OFS_STATUS)
                readdata <= {24'h00_0000, sequence_complete_flag, sar_busy, 3'b000, conv_index};
            else if (reg_index == adc_seq_pkg::OFS_TEST)
                readdata <= {16'h0000, {(16-RES_W){1'b0}}, approximation_register};
            else if (reg_index[3])
                readdata <= {16'h0000, format_result(results[reg_index[2:0]], result_justify, result_signed)};
        end
    end

    // Step enable from conversion time field
    step_divider #(
        .DIV_W (DIV_W)
    ) u_div (
        .mclk    (mclk),
        .srst    (conv_reset),
        .restart (seq_restart),
        .period  (DIV_W'(converter_control_four[adc_seq_pkg::POS_CONV_TIME_LO +: adc_seq_pkg::CONV_TIME_W])
                  + DIV_W'(adc_seq_pkg::STEP_BASE_CYCLES - 1)),
        .step_en (step_en)
    );

    sar_engine #(
        .RES_W (RES_W)
    ) u_sar (
        .mclk      (mclk),
        .srst      (conv_reset),
        .start     (start_conv),
        .abort     (seq_restart),
        .step_en   (step_en),
        .comp_high (comp_high),
        .approx    (approximation_register),
        .busy      (sar_busy),
        .done      (sar_done)
    );

    assign start_conv = (state == ST_START);
    assign seq_done   = sar_done && ({1'b0, conv_index} + 4'h1 == seq_len);

    // Sequencer
    always_ff @(posedge mclk)
    begin
        if (conv_reset)
        begin
            state       <= ST_IDLE;
            cur_channel <= 3'h0;
            conv_index  <= 3'h0;
            seq_len     <= adc_seq_pkg::SEQ_LEN_FOUR;
        end
        else if (seq_restart)
        begin
            // Abort and start at once; written value of control five takes effect
            state      <= ST_START;
            conv_index <= 3'h0;
            if (wr_five)
            begin
                cur_channel <= writedata[adc_seq_pkg::POS_CHAN_LO +: 3];
                seq_len     <= pick_length(single_conversion_select, writedata[adc_seq_pkg::POS_EIGHT_SEQ]);
            end
            else
            begin
                cur_channel <= {start_channel_bit2, start_channel_bit1, start_channel_bit0};
                seq_len     <= pick_length(single_conversion_select, eight_conversion_sequence);
            end
        end
        else
        begin
            case (state)
                ST_IDLE:
                    state <= ST_IDLE;
                ST_START:
                    state <= ST_CONVERT;
                ST_CONVERT:
                    if (sar_done)
                        state <= ST_STORE;
                ST_STORE:
                begin
                    if ({1'b0, conv_index} + 4'h1 >= seq_len)
                    begin
                        conv_index  <= 3'h0;
                        cur_channel <= {start_channel_bit2, start_channel_bit1, start_channel_bit0};
                        state       <= scan_mode ? ST_START : ST_IDLE;
                    end
                    else
                    begin
                        conv_index <= conv_index + 3'h1;
                        if (multi_mode)
                            cur_channel <= cur_channel + 3'h1;
                        state <= ST_START;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Result slot: by conversion index, or rolling position with FIFO
    always_ff @(posedge mclk)
    begin
        if (conv_reset)
        begin
            fifo_slot    <= 3'h0;
            result_valid <= 8'h00;
            for (int i = 0; i < 8; i++)
                results[i] <= '0;
        end
        else
        begin
            if (wr_five)
                result_valid <= 8'h00;
            if (wr_five && !fifo_enable)
                fifo_slot <= 3'h0;
            if (sar_done && !seq_restart)
            begin
                if (fifo_enable)
                begin
                    results[fifo_slot] <= approximation_register;
                    result_valid[fifo_slot] <= 1'b1;
                    fifo_slot <= fifo_slot + 3'h1;
                end
                else
                begin
                    results[conv_index] <= approximation_register;
                    result_valid[conv_index] <= 1'b1;
                end
            end
        end
    end

    // Complete flag: clear by control five write wins, as no set is taken during a restart
    always_comb
    begin
        next_complete = sequence_complete_flag;
        if (wr_five)
            next_complete = 1'b0;
        if (seq_done && !seq_restart)
            next_complete = 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (conv_reset)
            sequence_complete_flag <= 1'b0;
        else
            sequence_complete_flag <= next_complete;
    end

    // Front end drive
    always_ff @(posedge mclk)
    begin
        if (conv_reset)
        begin
            mux_channel               <= 3'h0;
            internal_reference_select <= 1'b0;
            dac_level                 <= '0;
            sample_en                 <= 1'b0;
        end
        else
        begin
            mux_channel               <= cur_channel;
            internal_reference_select <= converter_control_five[adc_seq_pkg::POS_SPECIAL];
            dac_level                 <= approximation_register;
            sample_en                 <= (state == ST_START);
        end
    end
endmodule

// ---- adc_sequence_control_props.sv ----
// Checker: bus handshake and sequencing properties of the converter block
`timescale 1ns/100ps
module adc_sequence_control_props (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        srst,
    // Register bus
    input wire logic [5:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // Converter side
    input wire logic [2:0]  mux_channel,
    input wire logic        internal_reference_select,
    input wire logic        sample_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    logic [3:0] idx;
    logic [2:0] last_chan;
    logic       first_due;
    logic       ctl5_seen;
    assign idx       = address[5:2];
    // First edge of the request, where the write takes effect
    assign ctl5_seen = write && waitrequest && idx == adc_seq_pkg::OFS_CONTROL_FIVE;

    // Write has priority so a stale pulse of the old sequence is ignored
    always_ff @(posedge mclk)
    begin
        if (srst)
            first_due <= 1'b0;
        else if (ctl5_seen)
            first_due <= 1'b1;
        else if (sample_en)
            first_due <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            last_chan <= 3'h0;
        else if (ctl5_seen)
            last_chan <= writedata[2:0];
    end

    sequence s_one_wait;
        waitrequest ##1 !waitrequest;
    endsequence

    sequence s_quiet;
        (!sample_en) [*8];
    endsequence

    a_wait_idle: assert property (!(read || write) |-> !waitrequest)
        else $error("waitrequest high without a request");
    a_wait_once: assert property ($rose(read || write) |-> s_one_wait)
        else $error("request not answered after one wait cycle");
    a_unmapped_zero: assert property (read && !waitrequest && (idx == 4'h6 || idx == 4'h7)
        |-> readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_sample_pulse: assert property (sample_en |=> !sample_en)
        else $error("sample enable longer than one cycle");
    a_first_channel: assert property (sample_en && first_due && !internal_reference_select |=> mux_channel == last_chan)
        else $error("sequence did not begin on the selected channel");
    a_ref_copy: assert property (ctl5_seen |-> ##2 internal_reference_select == $past(writedata[3], 2))
        else $error("reference select does not follow control five");
    a_ref_quiet: assert property ($changed(internal_reference_select)
        |-> $past(write && (idx == adc_seq_pkg::OFS_CONTROL_FIVE || idx == adc_seq_pkg::OFS_TEST)))
        else $error("reference select changed without a write");
    a_test_quiet: assert property (write && waitrequest && idx == adc_seq_pkg::OFS_TEST && writedata[15]
        |=> s_quiet)
        else $error("conversion continued after converter reset");
endmodule

bind adc_sequence_control adc_sequence_control_props u_adc_sequence_control_props (
    .mclk                      (mclk),
    .srst                      (srst),
    .address                   (address),
    .read                      (read),
    .write                     (write),
    .writedata                 (writedata),
    .readdata                  (readdata),
    .waitrequest               (waitrequest),
    .mux_channel               (mux_channel),
    .internal_reference_select (internal_reference_select),
    .sample_en                 (sample_en)
);

// ---- sar_engine.sv ----
// Successive approximation engine: one conversion, bit by bit
`timescale 1ns/100ps
module sar_engine #(
    parameter int RES_W = 10
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             srst,
    // Control
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic             step_en,
    // Comparator
    input  wire logic             comp_high,
    // Results
    output logic [RES_W-1:0]      approx,
    output logic                  busy,
    output logic                  done
);
    logic [RES_W-1:0] trial_bit;

    always_ff @(posedge mclk)
    begin
        if (srst || abort)
        begin
            approx    <= '0;
            trial_bit <= '0;
            busy      <= 1'b0;
            done      <= 1'b0;
        end
        else if (start)
        begin
            approx    <= {1'b1, {(RES_W-1){1'b0}}};
            trial_bit <= {1'b1, {(RES_W-1){1'b0}}};
            busy      <= 1'b1;
            done      <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (busy && step_en)
            begin
                // Keep the trial bit only when the input lies above the trial level
                if (!comp_high)
                    approx <= approx & ~trial_bit;
                if (trial_bit[0])
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                else
                begin
                    trial_bit <= trial_bit >> 1;
                    approx    <= (comp_high ? approx : (approx & ~trial_bit)) | (trial_bit >> 1);
                end
            end
        end
    end
endmodule

// ---- step_divider.sv ----
// Divider: one-cycle step enable at a programmable rate
`timescale 1ns/100ps
module step_divider #(
    parameter int DIV_W = 6
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             srst,
    // Control
    input  wire logic             restart,
    input  wire logic [DIV_W-1:0] period,
    // Enable out
    output logic                  step_en
);
    logic [DIV_W-1:0] count;

    always_ff @(posedge mclk)
    begin
        if (srst || restart)
        begin
            count   <= '0;
            step_en <= 1'b0;
        end
        else if (count >= period)
        begin
            count   <= '0;
            step_en <= 1'b1;
        end
        else
        begin
            count   <= count + 1'b1;
            step_en <= 1'b0;
        end
    end
endmodule

// ---- tb_adc_sequence_control.sv ----
// Testbench: register-level scenarios of the conversion sequencer
`timescale 1ns/100ps
module tb_adc_sequence_control;
    logic        mclk;
    logic        srst;
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        comp_high;
    logic [2:0]  mux_channel;
    logic        internal_reference_select;
    logic [9:0]  dac_level;
    logic        sample_en;
    logic [31:0] rd;
    int          miscompares;
    int          total_checks;
    int          cnt;

    adc_sequence_control u_adc_sequence_control (
        .mclk                      (mclk),
        .srst                      (srst),
        .address                   (address),
        .read                      (read),
        .write                     (write),
        .writedata                 (writedata),
        .readdata                  (readdata),
        .waitrequest               (waitrequest),
        .comp_high                 (comp_high),
        .mux_channel               (mux_channel),
        .internal_reference_select (internal_reference_select),
        .dac_level                 (dac_level),
        .sample_en                 (sample_en)
    );

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task summarize;
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Entered right after a rising edge; holds the request until waitrequest is low
    task bus(input logic wr, input logic [3:0] idx, input logic [31:0] d);
        int k;
        k = 0;
        address   <= {idx, 2'b00};
        writedata <= d;
        write     <= wr;
        read      <= !wr;
        @(posedge mclk);
        while (waitrequest !== 1'b0 && k < 20)
        begin
            @(posedge mclk);
            k++;
        end
        check({31'h0, waitrequest}, 32'h0000_0000);
        rd = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask

    task rdchk(input logic [3:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0000_0000);
        check(rd, exp);
    endtask

    // Returns one cycle after the next sample pulse, channel then settled
    task wait_sample;
        int k;
        k = 0;
        while (sample_en !== 1'b1 && k < 400)
        begin
            @(posedge mclk);
            k++;
        end
        check({31'h0, sample_en}, 32'h0000_0001);
        @(posedge mclk);
    endtask

    task wait_done;
        int k;
        k = 0;
        rd = 32'h0000_0000;
        while (rd[7] !== 1'b1 && k < 100)
        begin
            bus(1'b0, adc_seq_pkg::OFS_STATUS, 32'h0000_0000);
            k++;
        end
    endtask

    task count_samples(input int cycles);
        cnt = 0;
        repeat (cycles)
        begin
            // Look before waiting: the pulse launched by the write is still up here
            if (sample_en === 1'b1)
                cnt++;
            @(posedge mclk);
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        summarize;
    end

    initial
    begin
        srst = 1'b1;
        address = 6'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        comp_high = 1'b1;
        miscompares = 0;
        total_checks = 0;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        rdchk(adc_seq_pkg::OFS_CONTROL_TWO, 32'h0000_0000);
        rdchk(adc_seq_pkg::OFS_CONTROL_THREE, 32'h0000_0000);
        rdchk(adc_seq_pkg::OFS_CONTROL_FOUR, 32'h0000_0001);
        rdchk(adc_seq_pkg::OFS_CONTROL_FIVE, 32'h0000_0000);
        rdchk(adc_seq_pkg::OFS_STATUS, 32'h0000_0000);
        bus(1'b1, 4'h6, 32'h0000_00ff);
        rdchk(4'h6, 32'h0000_0000);
        bus(1'b1, adc_seq_pkg::OFS_CONTROL_THREE, 32'h0000_0003);
        rdchk(adc_seq_pkg::OFS_CONTROL_THREE, 32'h0000_0003);
        bus(1'b1, adc_seq_pkg::OFS_CONTROL_THREE, 32'h0000_0000);
        bus(1'b1, adc_seq_pkg::OFS_CONTROL_TWO, 32'h0000_0080);
        rdchk(adc_seq_pkg::OFS_CONTROL_TWO, 32'h0000_0080);
        bus(1'b1, adc_seq_pkg::OFS_CONTROL_FOUR, 32'h0000_0000);
        // Multi-channel runs from the chosen channel upward
        bus(1'b1, adc_seq_pkg::OFS_CONTROL_FIVE, 32'h0000_0015);
        wait_sample;
        check({29'h0, mux_channel}, 32'h0000_0005);
        wait_sample;
        check({29'h0, mux_channel}, 32'h0000_0006);
        bus(1'b1, adc_seq_pkg::OFS_CONTROL_FIVE, 32'h0000_0057);
        wait_sample;
        check({29'h0, mux_channel}, 32'h0000_0007);
        wait_sample;
        check({29'h0, mux_channel}, 32'h0000_0000);
        // Control four restarts from the first channel
        bus(1'b1, adc_seq_pkg::OFS_CONTROL_FOUR, 32'h0000_0000);
        wait_sample;
        check({29'h0, mux_channel}, 32'h0000_0007);
        bus(1'b1, adc_seq_pkg::OFS_CONTROL_TWO, 32'h0000_0080);
        wait_sample;
        check({29'h0, mux_channel}, 32'h0000_0000);
        bus(1'b1, adc_seq_pkg::OFS_CONTROL_THREE, 32'h0000_0000);
        wait_sample;
        check({29'h0, mux_channel}, 32'h0000_0001);
        bus(1'b1, adc_seq_pkg::OFS_CONTROL_FIVE, 32'h0000_0010);
        wait_done;
        check({30'h0, rd[7:6]}, 32'h0000_0002);
        count_samples(300);
        check(cnt, 0);
        bus(1'b1, adc_seq_pkg::OFS_CONTROL_FIVE, 32'h0000_0010);
        rdchk(adc_seq_pkg::OFS_STATUS, 32'h0000_0040);
        // Single select shortens the sequence to one conversion
        bus(1'b1, adc_seq_pkg::OFS_CONTROL_THREE, 32'h0000_0001);
        bus(1'b1, adc_seq_pkg::OFS_CONTROL_FIVE, 32'h0000_0050);
        count_samples(200);
        check(cnt, 1);
        rdchk(adc_seq_pkg::OFS_STATUS, 32'h0000_0080);
        bus(1'b0, adc_seq_pkg::OFS_TEST, 32'h0000_0000);
        check({22'h0, rd[9:0]}, 32'h0000_03ff);
        check({22'h0, dac_level}, 32'h0000_03ff);
        rdchk(adc_seq_pkg::OFS_RESULT0, 32'h0000_ffc0);
        bus(1'b1, adc_seq_pkg::OFS_TEST, 32'h0000_8000);
        bus(1'b0, adc_seq_pkg::OFS_TEST, 32'h0000_0000);
        check({22'h0, rd[9:0]}, 32'h0000_0000);
        bus(1'b1, adc_seq_pkg::OFS_CONTROL_THREE, 32'h0000_0000);
        bus(1'b1, adc_seq_pkg::OFS_CONTROL_FIVE, 32'h0000_0018);
        check({31'h0, internal_reference_select}, 32'h0000_0001);
        bus(1'b1, adc_seq_pkg::OFS_CONTROL_FIVE, 32'h0000_0010);
        check({31'h0, internal_reference_select}, 32'h0000_0000);
        // Continuous scan keeps converting after the flag sets
        bus(1'b1, adc_seq_pkg::OFS_CONTROL_FIVE, 32'h0000_0030);
        wait_done;
        check({31'h0, rd[7]}, 32'h0000_0001);
        count_samples(200);
        check({31'h0, cnt > 4}, 32'h0000_0001);
        rdchk(adc_seq_pkg::OFS_CONTROL_FIVE, 32'h0000_0030);
        summarize;
    end
endmodule
